// *** rtl/mdau_defs.vh ***
// constants for the data-move access unit: offsets, fields, reset values, timing
`ifndef MDAU_DEFS_VH
`define MDAU_DEFS_VH

// register byte offsets on the axi4-lite slave
`define MDAU_OFF_CTRL 8'h00
`define MDAU_OFF_PCR 8'h04
`define MDAU_OFF_PTR0 8'h08
`define MDAU_OFF_PTR1 8'h0C
`define MDAU_OFF_STAT 8'h10
`define MDAU_LAST_INDEX 6'h04

// control register fields
`define MDAU_CTRL_STRETCH_LSB 0
`define MDAU_CTRL_MAP_LO_BIT 8
`define MDAU_CTRL_MAP_HI_BIT 9
`define MDAU_STRETCH_RST 3'h1

// pointer choice register fields
`define MDAU_PCR_SEL_BIT 0
`define MDAU_PCR_SWAP_BIT 5
`define MDAU_PCR_DOWN0_BIT 6
`define MDAU_PCR_DOWN1_BIT 7
`define MDAU_PCR_MASK 8'hE1
`define MDAU_PCR_RST 8'h00

// status register fields
`define MDAU_STAT_BUSY_BIT 8

// data address map
`define MDAU_SRAM_TOP 16'h03FF
`define MDAU_LOCK_ADDR 16'hFFFC
`define MDAU_MAP_ALL_EXT 2'h0
`define MDAU_MAP_SRAM_EXT 2'h1
`define MDAU_MAP_RSVD 2'h2
`define MDAU_MAP_SRAM_LOCK 2'h3

// timing, in input clocks unless named otherwise
`define MDAU_CLK_PER_MC 6'h04
`define MDAU_INT_MC 6'h02
`define MDAU_ALE_BASE 6'h02
`define MDAU_SETUP_BASE 6'h01
`define MDAU_HOLD_BASE 6'h01
`define MDAU_SLOW_STRETCH 3'h4
`define MDAU_HALF_MC_CLK 6'h02

// axi responses
`define MDAU_RESP_OKAY 2'h0
`define MDAU_RESP_SLVERR 2'h2

`endif

// *** rtl/mdau_top.v ***
// data-move access unit: address map, stretched external bus, dual data pointers
//
// Function
// RULE1 - with on-chip ram enabled, 0000h-03FFh maps to the internal sram
// RULE2 - with on-chip ram enabled, addresses above the first 1kB go external
// RULE3 - with on-chip ram disabled (reset), all of 0000h-FFFFh goes external
// RULE4 - map 00 all external; 01 sram low, external from 0400h; 10 reserved
// RULE5 - map 11: sram low, 0400h-FFFBh no external, FFFCh lock status read
// RULE6 - lock status bits 2-0 read 1 when programmed; read only
// RULE7 - map bits may change anytime; new value used by later accesses
// RULE8 - internal sram accesses always take two machine cycles
// RULE9 - stretch 0-7 gives 2,3,4,5,9,10,11,12 cycles, strobe 0.5 to 7
// RULE10 - stretch resets to 1, three machine cycle external access
// RULE11 - stretch 1 adds one input clock to setup and hold
// RULE12 - stretch 4 and up widens ale, address hold, strobe, data hold
// RULE13 - beyond stretch 4 only the strobe widens
// RULE14 - stretch applies to data accesses only, never program fetch
// RULE15 - two 16-bit data pointers at consecutive register locations
// RULE16 - pointer choice bit 0 selects the active pointer for all uses
// RULE17 - bit 1 of pointer choice unused so increment toggles the choice
// RULE18 - increment changes active pointer only; bits 6/7 select count down
// RULE19 - auto-swap bit 5 toggles selection after each pointer operation
// RULE20 - with auto-swap, operate on current pointer first, then switch
// RULE21 - external bus: low address/data on port 0, high address on port 2
// RULE22 - map 11 reserved addresses: no bus cycle, reads zero, writes dropped
//
// Design decisions made here: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`include "mdau_defs.vh"

module mdau_top #(
    parameter SRAM_AW = 10
) (
    input wire aclk,
    input wire aresetn,
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    input wire mv_valid,
    output wire mv_ready,
    input wire mv_write,
    input wire mv_use_ptr,
    input wire [15:0] mv_addr,
    input wire [7:0] mv_wdata,
    output reg mv_done,
    output reg [7:0] mv_rdata,
    input wire ptr_inc,
    input wire ptr_load,
    input wire [15:0] ptr_load_value,
    input wire code_read_ptr,
    output wire [15:0] active_pointer,
    input wire [2:0] lock_status_bits,
    input wire [7:0] p0_in,
    output reg [7:0] p0_out,
    output reg p0_oe,
    output reg [7:0] p2_out,
    output reg p2_oe,
    output reg ale,
    output reg rd_n,
    output reg wr_n
);

    localparam ST_IDLE = 2'h0;
    localparam ST_INT = 2'h1;
    localparam ST_EXT = 2'h2;
    localparam ST_NONE = 2'h3;

    // machine cycles per external access
    function [5:0] mc_count;
        input [2:0] st;
        begin
            case (st)
                3'h0: mc_count = 6'h02;
                3'h1: mc_count = 6'h03;
                3'h2: mc_count = 6'h04;
                3'h3: mc_count = 6'h05;
                3'h4: mc_count = 6'h09;
                3'h5: mc_count = 6'h0A;
                3'h6: mc_count = 6'h0B;
                default: mc_count = 6'h0C;
            endcase
        end
    endfunction

    // strobe width in input clocks: half a machine cycle at 0, else st machine cycles
    function [5:0] strobe_clk;
        input [2:0] st;
        begin
            if (st == 3'h0) begin
                strobe_clk = `MDAU_HALF_MC_CLK;
            end else begin
                strobe_clk = {3'h0, st} * `MDAU_CLK_PER_MC;
            end
        end
    endfunction

    // setup or hold margin: one more clock from stretch 1, a machine cycle more from 4
    function [5:0] margin_clk;
        input [5:0] base;
        input [2:0] st;
        begin
            margin_clk = base;
            if (st != 3'h0) begin
                margin_clk = margin_clk + 6'h01;
            end
            if (st >= `MDAU_SLOW_STRETCH) begin
                margin_clk = margin_clk + `MDAU_CLK_PER_MC;
            end
        end
    endfunction

    // merge write data into an old word under the byte strobes
    function [31:0] apply_strobe;
        input [31:0] old;
        input [31:0] data;
        input [3:0] strb;
        integer i;
        begin
            apply_strobe = old;
            for (i = 0; i < 4; i = i + 1) begin
                if (strb[i]) begin
                    apply_strobe[i*8 +: 8] = data[i*8 +: 8];
                end
            end
        end
    endfunction

    // software-visible state
    reg [2:0] stretch_count;
    reg onchip_ram_map_hi;
    reg onchip_ram_map_lo;
    reg [7:0] pointer_choice_reg;
    reg [15:0] first_data_pointer;
    reg [15:0] second_data_pointer;

    // access engine state
    reg [1:0] state;
    reg [1:0] phase;
    reg [5:0] cnt;
    reg [15:0] a_addr;
    reg a_wr;
    reg a_ptr;
    reg [7:0] a_wdata;
    reg [2:0] a_st;
    reg [7:0] sram [0:(1 << SRAM_AW) - 1];

    // axi write side holding registers
    reg aw_full;
    reg w_full;
    reg [7:0] aw_addr_q;
    reg [31:0] w_data_q;
    reg [3:0] w_strb_q;

    wire [1:0] map_sel = {onchip_ram_map_hi, onchip_ram_map_lo};
    wire sel = pointer_choice_reg[`MDAU_PCR_SEL_BIT];
    wire swap_on = pointer_choice_reg[`MDAU_PCR_SWAP_BIT];
    assign active_pointer = sel ? second_data_pointer : first_data_pointer; // RULE16

    // new accesses start only on a machine-cycle boundary
    wire mc_start = (phase == 2'h0);
    assign mv_ready = (state == ST_IDLE) && mc_start;
    wire mv_fire = mv_valid && mv_ready;
    wire [15:0] eff_addr = mv_use_ptr ? active_pointer : mv_addr; // RULE16
    wire in_sram = (eff_addr <= `MDAU_SRAM_TOP);

    // target chosen from the map bits live at the start of each access
    reg [1:0] next_target;
    always @* begin
        case (map_sel) // RULE7
            `MDAU_MAP_SRAM_EXT: next_target = in_sram ? ST_INT : ST_EXT; // RULE1 RULE2 RULE4
            `MDAU_MAP_SRAM_LOCK: next_target = in_sram ? ST_INT : ST_NONE; // RULE5
            // reserved setting behaves as all external so nothing is lost
            `MDAU_MAP_RSVD: next_target = ST_EXT; // RULE4
            default: next_target = ST_EXT; // RULE3
        endcase
    end

    // external cycle timeline, in clocks from the start of the access
    wire [5:0] t_ale = margin_clk(`MDAU_ALE_BASE, a_st) - (a_st != 3'h0 ? 6'h01 : 6'h00); // RULE12
    wire [5:0] t_strb = t_ale + margin_clk(`MDAU_SETUP_BASE, a_st); // RULE11 RULE12 RULE13
    wire [5:0] t_strb_end = t_strb + strobe_clk(a_st); // RULE9 RULE13
    wire [5:0] t_hold_end = t_strb_end + margin_clk(`MDAU_HOLD_BASE, a_st); // RULE11 RULE12
    wire [5:0] t_last = (state == ST_EXT) ? mc_count(a_st) * `MDAU_CLK_PER_MC - 6'h01 :
        `MDAU_INT_MC * `MDAU_CLK_PER_MC - 6'h01; // RULE8 RULE9
    wire at_last = (state != ST_IDLE) && (cnt == t_last);

    // machine-cycle phase divider
    always @(posedge aclk) begin
        if (!aresetn) begin
            phase <= 2'h0;
        end else begin
            phase <= phase + 2'h1;
        end
    end

    // access sequencer
    always @(posedge aclk) begin
        if (!aresetn) begin
            state <= ST_IDLE;
            cnt <= 6'h00;
            a_addr <= 16'h0000;
            a_wr <= 1'b0;
            a_ptr <= 1'b0;
            a_wdata <= 8'h00;
            a_st <= `MDAU_STRETCH_RST;
        end else if (state == ST_IDLE) begin
            cnt <= 6'h00;
            if (mv_fire) begin
                state <= next_target;
                a_addr <= eff_addr;
                a_wr <= mv_write;
                a_ptr <= mv_use_ptr;
                a_wdata <= mv_wdata;
                a_st <= stretch_count; // RULE14
            end
        end else if (at_last) begin
            state <= ST_IDLE;
            cnt <= 6'h00;
        end else begin
            cnt <= cnt + 6'h01;
        end
    end

    // on-chip sram, touched in the last clock of the two-cycle access
    always @(posedge aclk) begin
        if (state == ST_INT && at_last && a_wr) begin
            sram[a_addr[SRAM_AW-1:0]] <= a_wdata; // RULE1
        end
    end

    // completion pulse and read data
    always @(posedge aclk) begin
        if (!aresetn) begin
            mv_done <= 1'b0;
            mv_rdata <= 8'h00;
        end else begin
            mv_done <= at_last;
            if (at_last && !a_wr && state == ST_INT) begin
                mv_rdata <= sram[a_addr[SRAM_AW-1:0]]; // RULE8
            end else if (at_last && !a_wr && state == ST_NONE) begin
                // reserved reads give zero, only the lock address answers
                if (a_addr == `MDAU_LOCK_ADDR) begin
                    mv_rdata <= {5'h00, lock_status_bits}; // RULE5 RULE6
                end else begin
                    mv_rdata <= 8'h00; // RULE22
                end
            end else if (state == ST_EXT && !a_wr && cnt == t_strb_end) begin
                // sampled in the last clock the read strobe is low on the pin
                mv_rdata <= p0_in;
            end
        end
    end

    // external pins, registered so they lag the counter by one clock
    always @(posedge aclk) begin
        if (!aresetn) begin
            p0_out <= 8'h00;
            p0_oe <= 1'b0;
            p2_out <= 8'h00;
            p2_oe <= 1'b0;
            ale <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
        end else if (state == ST_EXT) begin
            p2_oe <= 1'b1; // RULE21
            p2_out <= a_addr[15:8]; // RULE21
            ale <= (cnt < t_ale); // RULE12
            if (cnt < t_strb) begin
                p0_oe <= 1'b1; // RULE21
                p0_out <= a_addr[7:0];
            end else if (a_wr && cnt < t_hold_end) begin
                p0_oe <= 1'b1; // RULE12
                p0_out <= a_wdata;
            end else begin
                p0_oe <= 1'b0;
                p0_out <= 8'h00;
            end
            rd_n <= !(!a_wr && cnt >= t_strb && cnt < t_strb_end); // RULE9
            wr_n <= !(a_wr && cnt >= t_strb && cnt < t_strb_end); // RULE9
        end else begin
            // internal and reserved accesses leave the bus quiet
            p0_out <= 8'h00;
            p0_oe <= 1'b0; // RULE22
            p2_out <= 8'h00;
            p2_oe <= 1'b0;
            ale <= 1'b0;
            rd_n <= 1'b1;
            wr_n <= 1'b1;
        end
    end

    // axi write address/data capture, in either order
    wire aw_hs = s_axi_awvalid && s_axi_awready;
    wire w_hs = s_axi_wvalid && s_axi_wready;
    assign s_axi_awready = !aw_full && !s_axi_bvalid;
    assign s_axi_wready = !w_full && !s_axi_bvalid;
    wire [7:0] wr_addr = aw_full ? aw_addr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_full ? w_data_q : s_axi_wdata;
    wire [3:0] wr_strb = w_full ? w_strb_q : s_axi_wstrb;
    wire wr_fire = (aw_full || aw_hs) && (w_full || w_hs);
    wire wr_ok = (wr_addr[1:0] == 2'h0) && (wr_addr[7:2] <= `MDAU_LAST_INDEX);

    always @(posedge aclk) begin
        if (!aresetn) begin
            aw_full <= 1'b0;
            w_full <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 32'h0000_0000;
            w_strb_q <= 4'h0;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= `MDAU_RESP_OKAY;
        end else begin
            if (wr_fire) begin
                aw_full <= 1'b0;
                w_full <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_ok ? `MDAU_RESP_OKAY : `MDAU_RESP_SLVERR;
            end else begin
                if (aw_hs) begin
                    aw_full <= 1'b1;
                    aw_addr_q <= s_axi_awaddr;
                end
                if (w_hs) begin
                    w_full <= 1'b1;
                    w_data_q <= s_axi_wdata;
                    w_strb_q <= s_axi_wstrb;
                end
                if (s_axi_bvalid && s_axi_bready) begin
                    s_axi_bvalid <= 1'b0;
                end
            end
        end
    end

    // control register: stretch and map select
    wire [31:0] ctrl_word = {22'h00_0000, onchip_ram_map_hi, onchip_ram_map_lo, 5'h00,
        stretch_count};
    wire [31:0] ctrl_new = apply_strobe(ctrl_word, wr_data, wr_strb);
    always @(posedge aclk) begin
        if (!aresetn) begin
            stretch_count <= `MDAU_STRETCH_RST; // RULE10
            onchip_ram_map_hi <= 1'b0; // RULE3
            onchip_ram_map_lo <= 1'b0; // RULE3
        end else if (wr_fire && wr_addr == `MDAU_OFF_CTRL) begin
            // takes effect at the next access start; a running one keeps its copy
            stretch_count <= ctrl_new[`MDAU_CTRL_STRETCH_LSB +: 3]; // RULE7
            onchip_ram_map_hi <= ctrl_new[`MDAU_CTRL_MAP_HI_BIT]; // RULE7
            onchip_ram_map_lo <= ctrl_new[`MDAU_CTRL_MAP_LO_BIT]; // RULE7
        end
    end

    // pointer operations from the core and the auto-swap
    wire ptr_movx_done = at_last && a_ptr;
    wire swap_event = swap_on && (ptr_inc || ptr_load || code_read_ptr || ptr_movx_done);
    wire count_down = sel ? pointer_choice_reg[`MDAU_PCR_DOWN1_BIT] :
        pointer_choice_reg[`MDAU_PCR_DOWN0_BIT]; // RULE18
    wire [15:0] stepped = count_down ? active_pointer - 16'h0001 : active_pointer + 16'h0001;
    wire [15:0] op_value = ptr_load ? ptr_load_value : stepped;
    wire ptr_write = ptr_inc || ptr_load;
    wire [31:0] pcr_new = apply_strobe({24'h00_0000, pointer_choice_reg}, wr_data, wr_strb);
    wire [31:0] ptr0_new = apply_strobe({16'h0000, first_data_pointer}, wr_data, wr_strb);
    wire [31:0] ptr1_new = apply_strobe({16'h0000, second_data_pointer}, wr_data, wr_strb);

    // software writes take priority over a core operation in the same cycle
    always @(posedge aclk) begin
        if (!aresetn) begin
            pointer_choice_reg <= `MDAU_PCR_RST;
            first_data_pointer <= 16'h0000;
            second_data_pointer <= 16'h0000;
        end else begin
            if (wr_fire && wr_addr == `MDAU_OFF_PCR) begin
                // bit 1 is never stored, so an increment carries into nothing
                pointer_choice_reg <= pcr_new[7:0] & `MDAU_PCR_MASK; // RULE17
            end else if (swap_event) begin
                // the operation uses the old selection this cycle, the flip lands after
                pointer_choice_reg <= pointer_choice_reg ^ 8'h01; // RULE19 RULE20
            end
            if (wr_fire && wr_addr == `MDAU_OFF_PTR0) begin
                first_data_pointer <= ptr0_new[15:0]; // RULE15
            end else if (ptr_write && !sel) begin
                first_data_pointer <= op_value; // RULE18
            end
            if (wr_fire && wr_addr == `MDAU_OFF_PTR1) begin
                second_data_pointer <= ptr1_new[15:0]; // RULE15
            end else if (ptr_write && sel) begin
                second_data_pointer <= op_value; // RULE18
            end
        end
    end

    // axi read side, answered one clock after the address is taken
    assign s_axi_arready = !s_axi_rvalid;
    reg [31:0] rd_word;
    always @* begin
        case (s_axi_araddr)
            `MDAU_OFF_CTRL: rd_word = ctrl_word;
            `MDAU_OFF_PCR: rd_word = {24'h00_0000, pointer_choice_reg};
            `MDAU_OFF_PTR0: rd_word = {16'h0000, first_data_pointer};
            `MDAU_OFF_PTR1: rd_word = {16'h0000, second_data_pointer};
            `MDAU_OFF_STAT: rd_word = {23'h00_0000, state != ST_IDLE, 5'h00,
                lock_status_bits}; // RULE6
            default: rd_word = 32'h0000_0000;
        endcase
    end
    wire rd_ok = (s_axi_araddr[1:0] == 2'h0) && (s_axi_araddr[7:2] <= `MDAU_LAST_INDEX);

    always @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= `MDAU_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_ok ? `MDAU_RESP_OKAY : `MDAU_RESP_SLVERR;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

endmodule // mdau_top

// *** sim/mdau_top_properties.sv ***
// pin-level assertion checker for the data-move access unit
`timescale 1ns/1ps
module mdau_chk (
    input wire aclk,
    input wire aresetn,
    input wire mv_valid,
    input wire mv_ready,
    input wire mv_done,
    input wire ale,
    input wire rd_n,
    input wire wr_n,
    input wire p0_oe,
    input wire p2_oe
);
    reg [5:0] strobe_len;
    // strobe length counter, too long for a plain repetition
    always @(posedge aclk) begin
        if (!aresetn) begin
            strobe_len <= 6'h00;
        end else begin
            strobe_len <= (!rd_n || !wr_n) ? strobe_len + 6'h01 : 6'h00;
        end
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    sequence s_take;
        mv_valid && mv_ready;
    endsequence
    sequence s_no_ale;
        !ale [*2];
    endsequence
    AST_MV_MIN: assert property (s_take |=> !mv_done [*8])
        else $error("move finished before two machine cycles");
    AST_MV_MAX: assert property (s_take |-> ##[9:49] mv_done)
        else $error("move not finished within twelve machine cycles");
    AST_INT_TWO: assert property (s_take ##1 s_no_ale |-> ##7 mv_done)
        else $error("bus-free move not done in two machine cycles");
    AST_DONE_PULSE: assert property (mv_done |=> !mv_done)
        else $error("done wider than one clock");
    AST_ALE_MIN: assert property ($rose(ale) |-> ale [*2])
        else $error("address latch pulse too short");
    AST_ALE_MAX: assert property ($rose(ale) |-> ##[2:6] !ale)
        else $error("address latch pulse too long");
    AST_RD_MIN: assert property ($fell(rd_n) |-> !rd_n [*2])
        else $error("read strobe shorter than half a machine cycle");
    AST_STROBE_MAX: assert property (strobe_len <= 6'h1c)
        else $error("strobe longer than seven machine cycles");
    AST_RD_BUS: assert property (!rd_n |-> wr_n && !p0_oe && p2_oe && !ale)
        else $error("bus misdriven during read strobe");
    AST_WR_BUS: assert property (!wr_n |-> p0_oe && p2_oe && !ale)
        else $error("bus misdriven during write strobe");
endmodule // mdau_chk

bind mdau_top mdau_chk i_mdau_chk (.aclk(aclk), .aresetn(aresetn), .mv_valid(mv_valid),
    .mv_ready(mv_ready), .mv_done(mv_done), .ale(ale), .rd_n(rd_n), .wr_n(wr_n),
    .p0_oe(p0_oe), .p2_oe(p2_oe));

// *** sim/mdau_ext_mem.sv ***
// external byte memory model on the multiplexed port 0 / port 2 bus
`timescale 1ns/1ps
module mdau_ext_mem (
    input wire aclk,
    input wire [7:0] p0_out,
    input wire p0_oe,
    input wire [7:0] p2_out,
    input wire ale,
    input wire rd_n,
    input wire wr_n,
    output wire [7:0] p0_in
);
    logic [7:0] mem [0:65535];
    logic [15:0] alat = 16'h0000;
    logic [7:0] wdat = 8'h00;
    logic [7:0] last = 8'h00;
    logic wr_q = 1'b1;
    // known contents: high byte xor low byte of the address
    initial begin
        for (int i = 0; i < 65536; i++) begin
            mem[i] = i[15:8] ^ i[7:0];
        end
    end
    // address caught while the latch pulse is high, write stored on strobe release
    always @(posedge aclk) begin
        if (ale && p0_oe) alat <= {p2_out, p0_out};
        if (!wr_n) wdat <= p0_out;
        if (wr_n && !wr_q) mem[alat] <= wdat;
        wr_q <= wr_n;
        if (!rd_n) last <= mem[alat];
    end
    // released bus shows the inverse of the last byte so a stale value never passes
    assign p0_in = rd_n ? ~last : mem[alat];
endmodule // mdau_ext_mem

// *** sim/test_mdau_top.sv ***
// self-checking bench for the data-move access unit
`timescale 1ns/1ps
`include "mdau_defs.vh"
module test_mdau_top;
    logic aclk = 0;
    logic aresetn = 0;
    logic [7:0] awaddr = 0, araddr = 0, mv_wdata = 0, p0_in, p0_out, p2_out, mv_rdata;
    logic [31:0] wdata = 0, rdata, rv;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic awready, wready, bvalid, arready, rvalid, mv_ready, mv_done;
    logic p0_oe, p2_oe, ale, rd_n, wr_n;
    logic [1:0] bresp, rresp, rr;
    logic mv_valid = 0, mv_write = 0, mv_use_ptr = 0;
    logic ptr_inc = 0, ptr_load = 0, code_read_ptr = 0;
    logic [15:0] mv_addr = 0, ptr_load_value = 0, active_pointer;
    logic [2:0] lock_status_bits = 3'h5;
    int bad_count = 0, checked = 0, cyc, e, o, s;
    int nt[8] = '{2, 3, 4, 5, 9, 10, 11, 12};
    int wt[8] = '{2, 4, 8, 12, 16, 20, 24, 28};

    mdau_top i_mdau_top (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .mv_valid(mv_valid), .mv_ready(mv_ready),
        .mv_write(mv_write), .mv_use_ptr(mv_use_ptr), .mv_addr(mv_addr),
        .mv_wdata(mv_wdata), .mv_done(mv_done), .mv_rdata(mv_rdata), .ptr_inc(ptr_inc),
        .ptr_load(ptr_load), .ptr_load_value(ptr_load_value),
        .code_read_ptr(code_read_ptr), .active_pointer(active_pointer),
        .lock_status_bits(lock_status_bits), .p0_in(p0_in), .p0_out(p0_out),
        .p0_oe(p0_oe), .p2_out(p2_out), .p2_oe(p2_oe), .ale(ale), .rd_n(rd_n), .wr_n(wr_n));
    mdau_ext_mem i_mdau_ext_mem (.aclk(aclk), .p0_out(p0_out), .p0_oe(p0_oe),
        .p2_out(p2_out), .ale(ale), .rd_n(rd_n), .wr_n(wr_n), .p0_in(p0_in));

    // 100 MHz clock
    always #5 aclk = ~aclk;

    task chk(input [31:0] seen, input [31:0] exp);
        checked++;
        if (seen !== exp) begin
            bad_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    // axi write: both channels offered together, each dropped once taken
    task wr(input [7:0] a, input [31:0] d);
        logic ao, wo;
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1;
        wvalid <= 1;
        do begin
            @(negedge aclk);
            ao = awvalid && awready;
            wo = wvalid && wready;
            @(posedge aclk);
            if (ao) awvalid <= 0;
            if (wo) wvalid <= 0;
        end while (awvalid || wvalid);
        bready <= 1;
        do @(negedge aclk); while (bvalid !== 1'b1);
        rr = bresp;
        @(posedge aclk);
        bready <= 0;
    endtask

    task rd(input [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1;
        do @(negedge aclk); while (arready !== 1'b1);
        @(posedge aclk);
        arvalid <= 0;
        rready <= 1;
        do @(negedge aclk); while (rvalid !== 1'b1);
        rv = rdata;
        rr = rresp;
        @(posedge aclk);
        rready <= 0;
    endtask

    // one data move; counts clocks to done and clocks of latch, drive and strobe
    task mv(input w, input p, input [15:0] a, input [7:0] d);
        @(posedge aclk);
        mv_valid <= 1;
        mv_write <= w;
        mv_use_ptr <= p;
        mv_addr <= a;
        mv_wdata <= d;
        do @(negedge aclk); while (mv_ready !== 1'b1);
        @(posedge aclk);
        mv_valid <= 0;
        cyc = -1;
        e = 0;
        o = 0;
        s = 0;
        do begin
            @(negedge aclk);
            cyc++;
            e += ale;
            o += p0_oe;
            s += !(rd_n && wr_n);
        end while (mv_done !== 1'b1);
        rv = {24'h00_0000, mv_rdata};
    endtask

    task pop(input [2:0] k, input [15:0] v);
        @(posedge aclk);
        {ptr_inc, ptr_load, code_read_ptr} <= k;
        ptr_load_value <= v;
        @(posedge aclk);
        {ptr_inc, ptr_load, code_read_ptr} <= 3'h0;
        @(negedge aclk);
    endtask

    task end_of_test;
        $display("checked=%0d bad_count=%0d", checked, bad_count);
        if (bad_count == 0 && checked > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask

    // hang guard, far beyond the few hundred clocks the tests need
    initial begin
        #200000;
        bad_count++;
        end_of_test;
    end

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        rd(`MDAU_OFF_CTRL);
        chk(rv, 32'h0000_0001);
        rd(`MDAU_OFF_PCR);
        chk(rv, 32'h0000_0000);
        rd(`MDAU_OFF_STAT);
        chk(rv, 32'h0000_0005);
        rd(8'h14);
        chk(rr, `MDAU_RESP_SLVERR);
        $display("test reset done");
        mv(1, 0, 16'h0100, 8'h3c);
        chk(cyc, 12);
        chk(s, 4);
        mv(0, 0, 16'h0100, 8'h00);
        chk(rv, 32'h0000_003c);
        wr(`MDAU_OFF_CTRL, 32'h0000_0201);
        mv(0, 0, 16'h0100, 8'h00);
        chk(e, 2);
        for (int st = 0; st < 8; st++) begin
            wr(`MDAU_OFF_CTRL, 32'h0000_0100 | st);
            mv(0, 0, 16'h1234, 8'h00);
            chk(rv, 32'h0000_0026);
            chk(cyc, 4 * nt[st]);
            chk(s, wt[st]);
            chk(e, st > 3 ? 6 : 2);
            chk(o, st > 3 ? 12 : st > 0 ? 4 : 3);
        end
        mv(1, 0, 16'h03ff, 8'ha5);
        chk(cyc, 8);
        chk(e, 0);
        mv(0, 0, 16'h03ff, 8'h00);
        chk(rv, 32'h0000_00a5);
        wr(`MDAU_OFF_CTRL, 32'h0000_0001);
        mv(0, 0, 16'h03ff, 8'h00);
        chk(rv, 32'h0000_00fc);
        wr(`MDAU_OFF_CTRL, 32'h0000_0301);
        mv(0, 0, 16'hfffc, 8'h00);
        chk(rv, 32'h0000_0005);
        mv(0, 0, 16'h0800, 8'h00);
        chk(e, 0);
        mv(1, 0, 16'hfffd, 8'h77);
        chk(s, 0);
        mv(0, 0, 16'h03ff, 8'h00);
        chk(rv, 32'h0000_00a5);
        wr(`MDAU_OFF_STAT, 32'h0000_0000);
        chk(rr, `MDAU_RESP_OKAY);
        rd(`MDAU_OFF_STAT);
        chk(rv, 32'h0000_0005);
        $display("test map and stretch done");
        wr(`MDAU_OFF_CTRL, 32'h0000_0101);
        wr(`MDAU_OFF_PTR0, 32'h0000_0010);
        wr(`MDAU_OFF_PTR1, 32'h0000_2000);
        wr(`MDAU_OFF_PCR, 32'h0000_00a0);
        @(negedge aclk);
        chk(active_pointer, 16'h0010);
        pop(3'h4, 16'h0000);
        chk(active_pointer, 16'h2000);
        pop(3'h4, 16'h0000);
        chk(active_pointer, 16'h0011);
        rd(`MDAU_OFF_PTR1);
        chk(rv, 32'h0000_1fff);
        pop(3'h2, 16'h0400);
        chk(active_pointer, 16'h1fff);
        pop(3'h1, 16'h0000);
        chk(active_pointer, 16'h0400);
        mv(0, 1, 16'h0000, 8'h00);
        chk(rv, 32'h0000_0004);
        chk(active_pointer, 16'h1fff);
        wr(`MDAU_OFF_PCR, 32'h0000_0002);
        rd(`MDAU_OFF_PCR);
        chk(rv, 32'h0000_0000);
        $display("test pointers done");
        end_of_test;
    end
endmodule // test_mdau_top
